// ### design/sar_readout_pkg.sv
// Constants and types for the serial readout of the 12-bit converter.
// Assumes a single core clock; select and shift clock arrive through synchronisers.
package sar_readout_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Result layout
   localparam int RESULT_W = 12;
   localparam int IDX_W = 4;
   localparam logic [IDX_W-1:0] IDX_MSB = 4'hb;
   localparam logic [IDX_W-1:0] IDX_END = 4'hc;
   localparam logic [IDX_W-1:0] IDX_REPEAT_FIRST = 4'h1;
   localparam logic [RESULT_W-1:0] TRIAL_START = 12'h800;
   localparam logic [RESULT_W-1:0] TRIAL_RESET = 12'h000;

   ////////////////////////////////////////////////////////////////////////
   // Sampling phase: falling shift clock edges before the null bit
   localparam int CNT_W = 2;
   localparam logic [CNT_W-1:0] SAMPLE_LAST = 2'h1;

   ////////////////////////////////////////////////////////////////////////
   // Pin positions in the synchroniser vector and their reset levels
   localparam int PIN_N = 2;
   localparam int PIN_SCLK = 0;
   localparam int PIN_CS = 1;
   localparam logic [PIN_N-1:0] PIN_RESET = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT,
      ST_REPEAT,
      ST_DONE
   } state_e;

   typedef struct packed {
      logic dout;
      logic oe_n;
   } serial_out_s;

   localparam serial_out_s OUT_RESET = '{dout: 1'b0, oe_n: 1'b1};

endpackage : sar_readout_pkg

// ### design/sar_readout.sv
// Serial readout and successive approximation sequencer.
// Assumes select and shift clock come from the host, asynchronous to
// core_clk, and that the comparator output is on core_clk.
// Function
// - Select falling starts sampling, conversion and the serial transfer.
// - First two shift clock falls after select are spent sampling.
// - After the second fall, enable output and drive a low null bit.
// - Next twelve periods present the result, most significant bit first.
// - Every new output bit is launched on a shift clock falling edge.
// - After the least significant bit, bits 1 to 11 of the result repeat LSB first.
// - After the repeated most significant bit, output goes high impedance.
// - Once high impedance, further shift clocks change nothing.
// - New conversion only after select goes high then low again.
// - Output bits belong to the current conversion, no pipeline delay.
// - Result is straight binary, 000 zero to FFF full scale.
// - Select high puts the device in its shutdown state.
// - Host may raise select early after any number of bits.
// - Analog powers down after conversion; digital only while select high.
`timescale 1ns/10ps

module sar_readout (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic convert_select_n,
   input wire logic shift_clock,
   input wire logic comp_high,
   output logic dout,
   output logic dout_oe_n,
   output logic [sar_readout_pkg::RESULT_W-1:0] sar_trial,
   output logic sample_enable,
   output logic analog_power_on,
   output logic low_power_state
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   logic [1:0] rst_sync_reg;
   logic rst_sync_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   logic [sar_readout_pkg::PIN_N-1:0] pins_in;
   logic [sar_readout_pkg::PIN_N-1:0] s1_reg;
   logic [sar_readout_pkg::PIN_N-1:0] s2_reg;
   logic [sar_readout_pkg::PIN_N-1:0] s3_reg;
   logic [sar_readout_pkg::PIN_N-1:0] lvl_reg;
   logic [sar_readout_pkg::PIN_N-1:0] lvl_next;
   logic [sar_readout_pkg::PIN_N-1:0] fall;

   assign pins_in[sar_readout_pkg::PIN_CS] = convert_select_n;
   assign pins_in[sar_readout_pkg::PIN_SCLK] = shift_clock;

   genvar gi;
   generate
      for (gi = 0; gi < sar_readout_pkg::PIN_N; gi = gi + 1) begin : g_sync
         assign lvl_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] :
                               lvl_reg[gi];
         assign fall[gi] = lvl_reg[gi] & ~lvl_next[gi];
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s1_reg <= sar_readout_pkg::PIN_RESET;
         s2_reg <= sar_readout_pkg::PIN_RESET;
         s3_reg <= sar_readout_pkg::PIN_RESET;
         lvl_reg <= sar_readout_pkg::PIN_RESET;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   logic cs_high;
   logic cs_fall;
   logic sclk_fall;

   // Level taken from the agreeing stages so select high acts at once
   assign cs_high = lvl_next[sar_readout_pkg::PIN_CS];
   assign cs_fall = fall[sar_readout_pkg::PIN_CS];
   assign sclk_fall = fall[sar_readout_pkg::PIN_SCLK];

   ////////////////////////////////////////////////////////////////////////
   // Successive approximation trial word
   sar_readout_pkg::state_e state_reg;
   sar_readout_pkg::state_e state_next;
   logic [sar_readout_pkg::CNT_W-1:0] cnt_reg;
   logic [sar_readout_pkg::CNT_W-1:0] cnt_next;
   logic [sar_readout_pkg::IDX_W-1:0] idx_reg;
   logic [sar_readout_pkg::IDX_W-1:0] idx_next;
   logic [sar_readout_pkg::RESULT_W-1:0] trial_reg;
   logic [sar_readout_pkg::RESULT_W-1:0] trial_next;
   logic [sar_readout_pkg::RESULT_W-1:0] trial_dec;
   sar_readout_pkg::serial_out_s out_reg;
   sar_readout_pkg::serial_out_s out_next;
   logic sample_en_reg;
   logic analog_on_reg;
   logic low_power_reg;

   // Bit under decision takes the comparator, the next lower bit is tried
   generate
      for (gi = 0; gi < sar_readout_pkg::RESULT_W; gi = gi + 1) begin : g_dec
         assign trial_dec[gi] =
            (idx_reg == sar_readout_pkg::IDX_W'(gi)) ? comp_high :
            (idx_reg == sar_readout_pkg::IDX_W'(gi + 1)) ? 1'b1 :
            trial_reg[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      idx_next = idx_reg;
      trial_next = trial_reg;
      out_next = out_reg;
      if (cs_high) begin
         // Abandon whatever runs; shutdown until the next select fall
         state_next = sar_readout_pkg::ST_IDLE;
         out_next = sar_readout_pkg::OUT_RESET;
      end else begin
         case (state_reg)
            sar_readout_pkg::ST_IDLE: begin
               if (cs_fall) begin
                  state_next = sar_readout_pkg::ST_SAMPLE;
                  cnt_next = '0;
               end
            end
            sar_readout_pkg::ST_SAMPLE: begin
               if (sclk_fall) begin
                  if (cnt_reg == sar_readout_pkg::SAMPLE_LAST) begin
                     state_next = sar_readout_pkg::ST_CONVERT;
                     out_next.oe_n = 1'b0;
                     out_next.dout = 1'b0;
                     trial_next = sar_readout_pkg::TRIAL_START;
                     idx_next = sar_readout_pkg::IDX_MSB;
                  end else begin
                     cnt_next = cnt_reg + 2'h1;
                  end
               end
            end
            sar_readout_pkg::ST_CONVERT: begin
               if (sclk_fall) begin
                  // Bit goes out the moment it is decided
                  out_next.dout = comp_high;
                  trial_next = trial_dec;
                  if (idx_reg == '0) begin
                     state_next = sar_readout_pkg::ST_REPEAT;
                     idx_next = sar_readout_pkg::IDX_REPEAT_FIRST;
                  end else begin
                     idx_next = idx_reg - 4'h1;
                  end
               end
            end
            sar_readout_pkg::ST_REPEAT: begin
               if (sclk_fall) begin
                  if (idx_reg == sar_readout_pkg::IDX_END) begin
                     state_next = sar_readout_pkg::ST_DONE;
                     out_next = sar_readout_pkg::OUT_RESET;
                  end else begin
                     out_next.dout = trial_reg[idx_reg];
                     idx_next = idx_reg + 4'h1;
                  end
               end
            end
            sar_readout_pkg::ST_DONE: begin
               state_next = sar_readout_pkg::ST_DONE;
            end
            default: begin
               state_next = sar_readout_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= sar_readout_pkg::ST_IDLE;
         cnt_reg <= '0;
         idx_reg <= '0;
         trial_reg <= sar_readout_pkg::TRIAL_RESET;
         out_reg <= sar_readout_pkg::OUT_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         trial_reg <= trial_next;
         out_reg <= out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analog section controls and power state
   // Analog stays on only while sampling or deciding, to save current
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sample_en_reg <= 1'b0;
         analog_on_reg <= 1'b0;
         low_power_reg <= 1'b1;
      end else begin
         sample_en_reg <= (state_next == sar_readout_pkg::ST_SAMPLE);
         analog_on_reg <= (state_next == sar_readout_pkg::ST_SAMPLE) |
                          (state_next == sar_readout_pkg::ST_CONVERT);
         low_power_reg <= cs_high;
      end
   end

   assign dout = out_reg.dout;
   assign dout_oe_n = out_reg.oe_n;
   assign sar_trial = trial_reg;
   assign sample_enable = sample_en_reg;
   assign analog_power_on = analog_on_reg;
   assign low_power_state = low_power_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_start;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_IDLE) && cs_fall |=>
         (state_reg == sar_readout_pkg::ST_SAMPLE) && sample_enable;
   endproperty
   a_start: assert property (p_start)
      else $error("select fall did not start sampling");

   property p_null_bit;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_SAMPLE) && sclk_fall && !cs_high &&
      (cnt_reg == sar_readout_pkg::SAMPLE_LAST) |=>
         !dout_oe_n && !dout && (sar_trial == sar_readout_pkg::TRIAL_START);
   endproperty
   a_null_bit: assert property (p_null_bit)
      else $error("null bit not driven low after second fall");

   property p_quiet_sampling;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_SAMPLE) |-> dout_oe_n;
   endproperty
   a_quiet_sampling: assert property (p_quiet_sampling)
      else $error("output enabled during sampling");

   property p_msb_first;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_CONVERT) && sclk_fall && !cs_high |=>
         (dout == $past(comp_high)) &&
         (sar_trial[$past(idx_reg)] == $past(comp_high));
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("decided bit not shown on output");

   property p_launch_on_fall;
      @(posedge core_clk) disable iff (!rst_sync_n)
      $changed(dout) && !dout_oe_n |-> $past(sclk_fall);
   endproperty
   a_launch_on_fall: assert property (p_launch_on_fall)
      else $error("output changed without a shift clock fall");

   property p_repeat;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_REPEAT) && sclk_fall && !cs_high &&
      (idx_reg != sar_readout_pkg::IDX_END) |=>
         !dout_oe_n && (dout == sar_trial[$past(idx_reg)]);
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("repeated bit does not match result");

   property p_tristate_end;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_DONE) |-> dout_oe_n && !analog_power_on;
   endproperty
   a_tristate_end: assert property (p_tristate_end)
      else $error("output driven after repeat finished");

   property p_ignore_clocks;
      @(posedge core_clk) disable iff (!rst_sync_n)
      (state_reg == sar_readout_pkg::ST_DONE) && !cs_high |=>
         (state_reg == sar_readout_pkg::ST_DONE) && $stable(sar_trial);
   endproperty
   a_ignore_clocks: assert property (p_ignore_clocks)
      else $error("state changed after end of transfer");

   property p_deselect;
      @(posedge core_clk) disable iff (!rst_sync_n)
      cs_high |=> dout_oe_n && low_power_state && !analog_power_on &&
         (state_reg == sar_readout_pkg::ST_IDLE);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("select high did not shut the transfer down");

endmodule : sar_readout

// ### sim/host_model.sv
// Host side of the serial link: drives select and shift clock, samples output.
// Assumes core_clk is the only clock; pins change just after its rising edge.
`timescale 1ns/10ps

module host_model #(
   parameter int HALF = 6
) (
   input wire logic core_clk,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic sample_enable,
   output logic convert_select_n,
   output logic shift_clock
);
   // One entry per shift clock fall: {sample_enable, oe_n, masked data}
   logic [2:0] seen[$];

   initial begin
      convert_select_n = 1'b1;
      shift_clock = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic wait_cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cyc

   // Half period of six core cycles keeps the rate inside the host's range
   task automatic frame(int n, bit low);
      seen.delete();
      @(posedge core_clk);
      if (low) begin
         convert_select_n <= 1'b0;
      end
      wait_cyc(HALF);
      for (int i = 0; i < n; i++) begin
         shift_clock <= 1'b1;
         wait_cyc(HALF);
         shift_clock <= 1'b0;
         wait_cyc(HALF);
         // Taken where the next rise would be; clock then rests low
         seen.push_back({sample_enable, dout_oe_n, dout & ~dout_oe_n});
      end
   endtask : frame

   // Raising select may cut a frame short after any number of bits
   task automatic finish();
      convert_select_n <= 1'b1;
      wait_cyc(8);
   endtask : finish
endmodule : host_model

// ### sim/sar_adc_serial_readout_test.sv
// Self-checking bench: stream model per shift clock fall against the design.
// Assumes the host model drives the link and a comparator model closes the loop.
`timescale 1ns/10ps

module sar_adc_serial_readout_test;
   logic core_clk;
   logic rst_n;
   logic comp_high;
   logic convert_select_n;
   logic shift_clock;
   logic dout;
   logic dout_oe_n;
   logic [sar_readout_pkg::RESULT_W-1:0] sar_trial;
   logic sample_enable;
   logic analog_power_on;
   logic low_power_state;
   logic [11:0] vin;
   int fail_count;
   int checks;
   int seed;

   sar_readout uut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .convert_select_n(convert_select_n),
      .shift_clock(shift_clock),
      .comp_high(comp_high),
      .dout(dout),
      .dout_oe_n(dout_oe_n),
      .sar_trial(sar_trial),
      .sample_enable(sample_enable),
      .analog_power_on(analog_power_on),
      .low_power_state(low_power_state)
   );

   host_model host (
      .core_clk(core_clk),
      .dout(dout),
      .dout_oe_n(dout_oe_n),
      .sample_enable(sample_enable),
      .convert_select_n(convert_select_n),
      .shift_clock(shift_clock)
   );

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Ideal comparator: high when the input is at or above the trial word
   always @(posedge core_clk) begin
      comp_high <= (vin >= sar_trial);
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(logic [11:0] seen, logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // Expected {sample_enable, oe_n, data} after each fall, built as a queue
   task automatic compare_stream(int n, bit low, logic [11:0] v);
      logic [2:0] exp_q[$];
      for (int k = 1; k <= n; k++) begin
         if (!low) begin
            exp_q.push_back(3'b010);
         end else if (k == 1) begin
            exp_q.push_back(3'b110);
         end else if (k == 2) begin
            exp_q.push_back(3'b000);
         end else if (k <= 14) begin
            exp_q.push_back({2'b00, v[14-k]});
         end else if (k <= 25) begin
            exp_q.push_back({2'b00, v[k-14]});
         end else begin
            exp_q.push_back(3'b010);
         end
      end
      for (int k = 0; k < n; k++) begin
         check(12'(host.seen[k]), 12'(exp_q[k]));
         check(12'(host.seen[k]), 12'(exp_q[k]));
      end
   endtask : compare_stream

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [11:0] tbl[4];
      int n;
      tbl = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
      seed = 45;
      fail_count = 0;
      checks = 0;
      rst_n = 1'b0;
      comp_high = 1'b0;
      vin = 12'h000;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      check(12'({low_power_state, dout_oe_n}), 12'h003);
      check(sar_trial, 12'h000);
      // Clocks with select high must not wake the output
      host.frame(4, 1'b0);
      compare_stream(4, 1'b0, vin);
      // Code table, then random inputs; pass five is cut after eight bits
      for (int i = 0; i < 9; i++) begin
         vin <= (i < 4) ? tbl[i] : 12'($random(seed));
         n = (i == 5) ? 10 : 28;
         host.frame(n, 1'b1);
         compare_stream(n, 1'b1, vin);
         if (n == 28) begin
            check(sar_trial, vin);
            check(12'({analog_power_on, low_power_state}), 12'h000);
         end
         host.finish();
         check(12'({low_power_state, dout_oe_n}), 12'h003);
      end
      end_sim();
   end

   // A hung run counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
endmodule : sar_adc_serial_readout_test
